// File: shared/etocc_pkg.sv
// package: register map, field positions and modes of the enhanced timer output block
package etocc_pkg;
	// register byte addresses (word aligned)
	localparam logic [5:0] ADDR_CTRL0    = 6'h00;
	localparam logic [5:0] ADDR_CTRL_A   = 6'h04;
	localparam logic [5:0] ADDR_CTRL_B   = 6'h08;
	localparam logic [5:0] ADDR_CNT_LO   = 6'h0c;
	localparam logic [5:0] ADDR_CNT_HI   = 6'h10;
	localparam logic [5:0] ADDR_CMPA_LO  = 6'h14;
	localparam logic [5:0] ADDR_CMPA_HI  = 6'h18;
	localparam logic [5:0] ADDR_CMPB_LO  = 6'h1c;
	localparam logic [5:0] ADDR_CMPB_HI  = 6'h20;
	localparam logic [5:0] ADDR_ADJ_LAST = 6'h20;
	// control register 0 (own): timer on bit and period comparator value
	localparam int         ON_POS        = 3;
	localparam int         PER_POS       = 0;
	// mode / pin function / level / invert field positions (A and B alike)
	localparam int         MODE_POS      = 6;
	localparam int         FUNC_POS      = 4;
	localparam int         LEVEL_POS     = 3;
	localparam int         INV_POS       = 2;
	localparam int         DIR_POS       = 1;
	localparam int         CLR_POS       = 0;
	localparam int         ALIGN_POS     = 0;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	localparam logic [9:0] CMP_RESET     = 10'h000;
	localparam logic [9:0] CNT_MAX       = 10'h3ff;
	// channel modes
	localparam logic [1:0] MODE_CMP      = 2'h0;
	localparam logic [1:0] MODE_CAP      = 2'h1;
	localparam logic [1:0] MODE_PWM      = 2'h2;
	localparam logic [1:0] MODE_TMR      = 2'h3;
	// compare output pin functions
	localparam logic [1:0] CF_NONE       = 2'h0;
	localparam logic [1:0] CF_LOW        = 2'h1;
	localparam logic [1:0] CF_HIGH       = 2'h2;
	localparam logic [1:0] CF_TOGGLE     = 2'h3;
	// pwm pin functions
	localparam logic [1:0] PF_INACTIVE   = 2'h0;
	localparam logic [1:0] PF_ACTIVE     = 2'h1;
	localparam logic [1:0] PF_PWM        = 2'h2;
	localparam logic [1:0] PF_PULSE      = 2'h3;
	// capture triggers
	localparam logic [1:0] CAP_RISE      = 2'h0;
	localparam logic [1:0] CAP_FALL      = 2'h1;
	localparam logic [1:0] CAP_BOTH      = 2'h2;
	// pwm alignment
	localparam logic [1:0] AL_EDGE       = 2'h0;
	localparam logic [1:0] AL_UP         = 2'h1;
	localparam logic [1:0] AL_DOWN       = 2'h2;
	localparam logic [1:0] AL_BOTH       = 2'h3;
	localparam int         NUM_B_PINS    = 3;
endpackage

// File: src/etocc_top.sv
// module: 10-bit up/down timer with two compare/capture channels and wishbone registers
module etocc_top
	import etocc_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [31:0]           wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       wb_err_o,
	input  wire logic                  count_en_i,
	input  wire logic                  chan_a_pin_i,
	output logic                       chan_a_pin_o,
	output logic                       chan_a_pin_oe_n_o,
	input  wire logic [NUM_B_PINS-1:0] chan_b_pin_i,
	output logic      [NUM_B_PINS-1:0] chan_b_pin_o,
	output logic      [NUM_B_PINS-1:0] chan_b_pin_oe_n_o
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic       timer_on_bit;
	logic [2:0] period_compare_value;
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic [9:0] compare_a_value;
	logic [9:0] compare_b_value;
	logic [9:0] count;
	logic       count_dir_flag;
	logic       on_q;
	logic       on_rise;
	logic       req;
	logic       hit;
	logic [7:0] wbyte;
	logic [7:0] next_rdata;

	assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign hit   = (wb_adr_i[31:6] == 26'h0) && (wb_adr_i[1:0] == 2'h0)
		&& (wb_adr_i[5:0] <= ADDR_ADJ_LAST);
	assign wbyte = wb_dat_i[7:0];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_on_bit         <= 1'b0;
			period_compare_value <= 3'h0;
			ctrl_a               <= CTRL_RESET;
			ctrl_b               <= CTRL_RESET;
			compare_a_value      <= CMP_RESET;
			compare_b_value      <= CMP_RESET;
		end
		else if (req && hit && wb_we_i && wb_sel_i[0])
		begin
			case (wb_adr_i[5:0])
				ADDR_CTRL0:
				begin
					timer_on_bit         <= wbyte[ON_POS];
					period_compare_value <= wbyte[PER_POS+:3];
				end
				ADDR_CTRL_A:  ctrl_a <= {wbyte[7:2], 1'b0, wbyte[CLR_POS]};
				ADDR_CTRL_B:  ctrl_b <= wbyte;
				ADDR_CMPA_LO: compare_a_value[7:0] <= wbyte;
				ADDR_CMPA_HI: compare_a_value[9:8] <= wbyte[1:0];
				ADDR_CMPB_LO: compare_b_value[7:0] <= wbyte;
				ADDR_CMPB_HI: compare_b_value[9:8] <= wbyte[1:0];
				default:      ;
			endcase
		end
	end

	always_comb
	begin
		next_rdata = 8'h00;
		case (wb_adr_i[5:0])
			ADDR_CTRL0:   next_rdata = {4'h0, timer_on_bit, period_compare_value};
			ADDR_CTRL_A:  next_rdata = {ctrl_a[7:2], count_dir_flag, ctrl_a[CLR_POS]};
			ADDR_CTRL_B:  next_rdata = ctrl_b;
			ADDR_CNT_LO:  next_rdata = count[7:0];
			ADDR_CNT_HI:  next_rdata = {6'h00, count[9:8]};
			ADDR_CMPA_LO: next_rdata = compare_a_value[7:0];
			ADDR_CMPA_HI: next_rdata = {6'h00, compare_a_value[9:8]};
			ADDR_CMPB_LO: next_rdata = compare_b_value[7:0];
			ADDR_CMPB_HI: next_rdata = {6'h00, compare_b_value[9:8]};
			default:      next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= req && hit;
			wb_err_o <= req && !hit;
			if (req && hit && !wb_we_i)
				wb_dat_o <= {24'h0, next_rdata};
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------
	logic [1:0] mode_a;
	logic [1:0] mode_b;
	logic [1:0] align;
	logic       centre;
	logic       match_a;
	logic       match_b;
	logic       match_p;
	logic       clear_now;
	logic       tick;

	assign mode_a  = ctrl_a[MODE_POS+:2];
	assign mode_b  = ctrl_b[MODE_POS+:2];
	assign align   = ctrl_b[ALIGN_POS+:2];
	assign centre  = (mode_b == MODE_PWM) && (align != AL_EDGE);
	assign tick    = timer_on_bit && count_en_i;
	assign on_rise = timer_on_bit && !on_q;
	assign match_a = tick && (count == compare_a_value);
	assign match_b = tick && (count == compare_b_value);
	// period match on the top three bits, zero means a full 1024 count
	assign match_p = tick && (period_compare_value != 3'h0)
		&& (count == {period_compare_value, 7'h00});

	always_comb
	begin
		clear_now = 1'b0;
		if (mode_b == MODE_CAP)
			clear_now = 1'b0;
		else if (ctrl_a[CLR_POS] && !(mode_b == MODE_PWM && ctrl_b[FUNC_POS+:2] == PF_PULSE))
			clear_now = match_a;
		else
			clear_now = match_p;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			on_q <= 1'b0;
		else
			on_q <= timer_on_bit;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count          <= 10'h000;
			count_dir_flag <= 1'b0;
		end
		else if (on_rise)
		begin
			count          <= 10'h000;
			count_dir_flag <= 1'b0;
		end
		else if (tick)
		begin
			if (centre)
			begin
				if (!count_dir_flag && (clear_now || count == CNT_MAX))
					count_dir_flag <= 1'b1;
				else if (count_dir_flag && count == 10'h001)
					count_dir_flag <= 1'b0;
				count <= count_dir_flag ? count - 10'h001 : count + 10'h001;
			end
			else if (clear_now)
				count <= 10'h000;
			else
				count <= count + 10'h001; // wraps at full range
		end
	end

	// ----------------------------------------------------------------
	// channel pins
	// ----------------------------------------------------------------
	logic [1:0] ch_mode  [2];
	logic [1:0] ch_func  [2];
	logic       ch_level [2];
	logic       ch_inv   [2];
	logic       ch_match [2];
	logic       ch_in    [2];
	logic       ch_out   [2];
	logic       ch_oe_n  [2];
	logic       ch_cap   [2];

	assign ch_mode[0]  = mode_a;
	assign ch_mode[1]  = mode_b;
	assign ch_match[0] = match_a;
	assign ch_match[1] = match_b;
	assign ch_in[0]    = chan_a_pin_i;
	assign ch_in[1]    = chan_b_pin_i[0];

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_chan
			logic state;
			logic in_q;
			logic pulse_done;
			logic phase_ok;
			logic active;
			assign ch_func[g]  = (g == 0) ? ctrl_a[FUNC_POS+:2] : ctrl_b[FUNC_POS+:2];
			assign ch_level[g] = (g == 0) ? ctrl_a[LEVEL_POS] : ctrl_b[LEVEL_POS];
			assign ch_inv[g]   = (g == 0) ? ctrl_a[INV_POS] : ctrl_b[INV_POS];
			// centre aligned duty match only in the selected direction
			assign phase_ok = !centre || align == AL_BOTH
				|| (align == AL_UP && !count_dir_flag) || (align == AL_DOWN && count_dir_flag);

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					state      <= 1'b0;
					pulse_done <= 1'b0;
				end
				else if (on_rise)
				begin
					state      <= ch_level[g];
					pulse_done <= 1'b0;
				end
				else if (ch_mode[g] == MODE_CMP && ch_match[g])
				begin
					case (ch_func[g])
						CF_LOW:    state <= 1'b0;
						CF_HIGH:   state <= 1'b1;
						CF_TOGGLE: state <= !state;
						default:   state <= state;
					endcase
				end
				else if (ch_mode[g] == MODE_PWM && ch_match[g] && phase_ok)
					pulse_done <= 1'b1;
			end

			// active phase before the duty match
			always_comb
			begin
				active = 1'b0;
				case (ch_func[g])
					PF_INACTIVE: active = 1'b0;
					PF_ACTIVE:   active = 1'b1;
					PF_PWM:      active = timer_on_bit && (centre ?
						(count < ((g == 0) ? compare_a_value : compare_b_value))
						: (count < ((g == 0) ? compare_a_value : compare_b_value)));
					PF_PULSE:    active = timer_on_bit && !pulse_done;
					default:     active = 1'b0;
				endcase
			end

			always_comb
			begin
				ch_out[g]  = 1'b0;
				ch_oe_n[g] = 1'b1;
				case (ch_mode[g])
					MODE_CMP:
					begin
						ch_out[g]  = state ^ ch_inv[g];
						ch_oe_n[g] = 1'b0;
					end
					MODE_PWM:
					begin
						ch_out[g]  = (active ~^ ch_level[g]) ^ ch_inv[g];
						ch_oe_n[g] = 1'b0;
					end
					default:
					begin
						ch_out[g]  = 1'b0; // pin released
						ch_oe_n[g] = 1'b1;
					end
				endcase
			end

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					in_q <= 1'b0;
				else
					in_q <= ch_in[g];
			end

			always_comb
			begin
				ch_cap[g] = 1'b0;
				case (ch_func[g])
					CAP_RISE: ch_cap[g] = ch_in[g] && !in_q;
					CAP_FALL: ch_cap[g] = !ch_in[g] && in_q;
					CAP_BOTH: ch_cap[g] = ch_in[g] != in_q;
					default:  ch_cap[g] = 1'b0;
				endcase
				if (ch_mode[g] != MODE_CAP)
					ch_cap[g] = 1'b0;
			end
		end
	endgenerate

	// captured count for channel pins; held in cap_a and cap_b, not readable on the bus
	logic [9:0] cap_a;
	logic [9:0] cap_b;
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cap_a <= 10'h000;
			cap_b <= 10'h000;
		end
		else
		begin
			if (ch_cap[0])
				cap_a <= count;
			if (ch_cap[1])
				cap_b <= count;
		end
	end

	assign chan_a_pin_o      = ch_out[0];
	assign chan_a_pin_oe_n_o = ch_oe_n[0];
	assign chan_b_pin_o      = {NUM_B_PINS{ch_out[1]}};
	assign chan_b_pin_oe_n_o = {NUM_B_PINS{ch_oe_n[1]}};

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_on_edge;
		!timer_on_bit ##1 timer_on_bit;
	endsequence

	chk_on_clears_count: assert property (@(posedge clk_i) disable iff (rst_i)
		s_on_edge |=> (count == 10'h000))
		else $error("count not zero after timer on");
	chk_off_holds_count: assert property (@(posedge clk_i) disable iff (rst_i)
		!timer_on_bit && $past(!timer_on_bit) |-> $stable(count))
		else $error("count moved while off");
	chk_init_level: assert property (@(posedge clk_i) disable iff (rst_i)
		s_on_edge ##0 (mode_a == MODE_CMP) |=> (chan_a_pin_o == ($past(ctrl_a[LEVEL_POS]) ^ ctrl_a[INV_POS]))
		|| $changed(ctrl_a))
		else $error("channel a not at initial level");
	chk_tmr_release: assert property (@(posedge clk_i) disable iff (rst_i)
		(mode_b == MODE_TMR) |-> (chan_b_pin_oe_n_o == {NUM_B_PINS{1'b1}}))
		else $error("pin driven in timer mode");
	chk_hi_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o && $past(wb_adr_i[5:0] == ADDR_CNT_HI && !wb_we_i) |-> (wb_dat_o[7:2] == 6'h00))
		else $error("high byte upper bits not zero");
	chk_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		match_a && ctrl_a[CLR_POS] && mode_b == MODE_CMP && !on_rise |=> (count == 10'h000))
		else $error("compare a did not clear counter");
	chk_cap_no_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		tick && mode_b == MODE_CAP && !on_rise && count != CNT_MAX |=> count == $past(count) + 10'h001)
		else $error("counter cleared in capture mode");
	chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o))
		else $error("bus answer not one cycle");
	chk_cap_store: assert property (@(posedge clk_i) disable iff (rst_i)
		(ch_cap[0] || ch_cap[1]) |=> (!$past(ch_cap[0]) || cap_a == $past(count))
		&& (!$past(ch_cap[1]) || cap_b == $past(count)))
		else $error("capture did not store count");
endmodule

// File: verif/etocc_pin_model.sv
// pin model: resolves the channel pins from the timer drive and an outside source
module etocc_pin_model
	import etocc_pkg::*;
(
	input  wire logic                  a_drv_i,
	input  wire logic                  a_oe_n_i,
	input  wire logic [NUM_B_PINS-1:0] b_drv_i,
	input  wire logic [NUM_B_PINS-1:0] b_oe_n_i,
	input  wire logic                  ext_a_i,
	input  wire logic [NUM_B_PINS-1:0] ext_b_i,
	output logic                       a_wire_o,
	output logic      [NUM_B_PINS-1:0] b_wire_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// -----------------------------------------------------------------
	// wire resolution
	// -----------------------------------------------------------------
	// the outside source only drives a pin that the timer has released
	assign a_wire_o = a_oe_n_i ? ext_a_i : a_drv_i;
	always_comb
	begin
		for (int i = 0; i < NUM_B_PINS; i++)
			b_wire_o[i] = b_oe_n_i[i] ? ext_b_i[i] : b_drv_i[i];
	end
endmodule

// File: verif/etocc_top_tb.sv
// testbench: register map and output pin behaviour of the enhanced timer block
module etocc_top_tb
	import etocc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic                  wb_cyc_i = 1'b0;
	logic                  wb_stb_i = 1'b0;
	logic                  wb_we_i = 1'b0;
	logic [31:0]           wb_adr_i = 32'h0;
	logic [3:0]            wb_sel_i = 4'hf;
	logic [31:0]           wb_dat_i = 32'h0;
	logic [31:0]           wb_dat_o;
	logic                  wb_ack_o;
	logic                  wb_err_o;
	logic                  count_en_i = 1'b0;
	logic                  chan_a_pin_i;
	logic                  chan_a_pin_o;
	logic                  chan_a_pin_oe_n_o;
	logic [NUM_B_PINS-1:0] chan_b_pin_i;
	logic [NUM_B_PINS-1:0] chan_b_pin_o;
	logic [NUM_B_PINS-1:0] chan_b_pin_oe_n_o;
	logic [31:0]           q;
	logic                  e;
	int                    errors = 0;
	int                    check_count = 0;

	always #4 clk_i = ~clk_i;

	etocc_pin_model pins (
		.a_drv_i  (chan_a_pin_o),
		.a_oe_n_i (chan_a_pin_oe_n_o),
		.b_drv_i  (chan_b_pin_o),
		.b_oe_n_i (chan_b_pin_oe_n_o),
		.ext_a_i  (1'b1),
		.ext_b_i  (3'h5),
		.a_wire_o (chan_a_pin_i),
		.b_wire_o (chan_b_pin_i)
	);

	etocc_top DUT (
		.clk_i             (clk_i),
		.rst_i             (rst_i),
		.wb_cyc_i          (wb_cyc_i),
		.wb_stb_i          (wb_stb_i),
		.wb_we_i           (wb_we_i),
		.wb_adr_i          (wb_adr_i),
		.wb_sel_i          (wb_sel_i),
		.wb_dat_i          (wb_dat_i),
		.wb_dat_o          (wb_dat_o),
		.wb_ack_o          (wb_ack_o),
		.wb_err_o          (wb_err_o),
		.count_en_i        (count_en_i),
		.chan_a_pin_i      (chan_a_pin_i),
		.chan_a_pin_o      (chan_a_pin_o),
		.chan_a_pin_oe_n_o (chan_a_pin_oe_n_o),
		.chan_b_pin_i      (chan_b_pin_i),
		.chan_b_pin_o      (chan_b_pin_o),
		.chan_b_pin_oe_n_o (chan_b_pin_oe_n_o)
	);

	// -----------------------------------------------------------------
	// checking and closing
	// -----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// wishbone classic cycle
	// -----------------------------------------------------------------
	task automatic wb_xfer(input logic we, input logic [31:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_i);
			if (wb_ack_o === 1'b1 || wb_err_o === 1'b1)
				break;
		end
		q = wb_dat_o;
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (n == 20)
		begin
			errors++;
			give_verdict();
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		wb_xfer(1'b1, a, d);
	endtask

	task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
		wb_xfer(1'b0, a, 8'h0);
		check(what, q, exp);
	endtask

	// counter steps on exactly n enabled cycles
	task automatic run(input int n);
		@(posedge clk_i);
		count_en_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		count_en_i <= 1'b0;
	endtask

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i <= 8; i++)
			rd_chk("reset value", 32'(i * 4), 32'h0);
		check("b enable at reset", 32'(chan_b_pin_oe_n_o), 32'h0);
		wr(ADDR_CMPA_LO, 8'h05);
		wr(ADDR_CMPA_HI, 8'hff);
		rd_chk("cmpa lo", ADDR_CMPA_LO, 32'h05);
		rd_chk("cmpa hi", ADDR_CMPA_HI, 32'h03);
		wr(ADDR_CMPB_LO, 8'ha5);
		wr(ADDR_CMPB_HI, 8'hfe);
		rd_chk("cmpb lo", ADDR_CMPB_LO, 32'ha5);
		rd_chk("cmpb hi", ADDR_CMPB_HI, 32'h02);
		wr(ADDR_CNT_LO, 8'h77);
		rd_chk("cnt lo write", ADDR_CNT_LO, 32'h0);
		wb_xfer(1'b0, 32'h24, 8'h0);
		check("unmapped err", 32'(e), 32'h1);
		// compare A: initial high, driven low on match
		wr(ADDR_CMPA_HI, 8'h00);
		wr(ADDR_CTRL_A, 8'h18);
		wr(ADDR_CTRL0, 8'h08);
		rd_chk("cnt after on", ADDR_CNT_LO, 32'h0);
		check("pin a initial", 32'(chan_a_pin_i), 32'h1);
		run(10);
		rd_chk("cnt ten steps", ADDR_CNT_LO, 32'h0a);
		check("pin a after match", 32'(chan_a_pin_i), 32'h0);
		rd_chk("ctrl a dir up", ADDR_CTRL_A, 32'h18);
		wr(ADDR_CTRL0, 8'h00);
		rd_chk("cnt held off", ADDR_CNT_LO, 32'h0a);
		wr(ADDR_CTRL0, 8'h08);
		@(posedge clk_i);
		check("pin a restored", 32'(chan_a_pin_i), 32'h1);
		rd_chk("cnt restart", ADDR_CNT_LO, 32'h0);
		wr(ADDR_CTRL_A, 8'h1c);
		check("pin a inverted", 32'(chan_a_pin_i), 32'h0);
		// compare A match clears the counter
		wr(ADDR_CTRL0, 8'h00);
		wr(ADDR_CTRL_A, 8'h19);
		wr(ADDR_CTRL0, 8'h08);
		run(10);
		wb_xfer(1'b0, ADDR_CNT_LO, 8'h0);
		check("cnt cleared by a", q, 32'h4);
		// capture mode ignores the clear select, counter runs past compare A
		wr(ADDR_CTRL0, 8'h00);
		wr(ADDR_CTRL_B, 8'h40);
		wr(ADDR_CTRL0, 8'h08);
		run(10);
		rd_chk("cnt no clear capture", ADDR_CNT_LO, 32'h0a);
		// period value 1 clears the counter after count 128
		wr(ADDR_CTRL0, 8'h00);
		wr(ADDR_CTRL_A, 8'h18);
		wr(ADDR_CTRL_B, 8'h00);
		wr(ADDR_CTRL0, 8'h09);
		run(130);
		rd_chk("cnt period clear", ADDR_CNT_LO, 32'h01);
		// channel B modes, changed only while the timer is off
		wr(ADDR_CTRL0, 8'h00);
		wr(ADDR_CTRL_B, 8'hc0);
		check("b released in timer", 32'(chan_b_pin_oe_n_o), 32'h7);
		wr(ADDR_CTRL_B, 8'h98);
		check("b forced active hi", 32'(chan_b_pin_i), 32'h7);
		wr(ADDR_CTRL_B, 8'h88);
		check("b forced inactive", 32'(chan_b_pin_i), 32'h0);
		wr(ADDR_CTRL_B, 8'h90);
		check("b active low", 32'(chan_b_pin_i), 32'h0);
		give_verdict();
	end
endmodule
